//--- common/asif_params.svh
// Constants for the serial interface flag and low-power block.
// Included by the package and the flag logic file; definitions only.
`ifndef ASIF_PARAMS_SVH
`define ASIF_PARAMS_SVH

// Status one bit positions
`define ASIF_SR1_TXE_BIT 7
`define ASIF_SR1_TXC_BIT 6
`define ASIF_SR1_RXF_BIT 5
`define ASIF_SR1_IDLE_BIT 4
`define ASIF_SR1_OR_BIT 3

// Alternative status bit positions
`define ASIF_ASR_EDGE_BIT 7
`define ASIF_ASR_BERR_BIT 1
`define ASIF_ASR_BRK_BIT 0

// Idle run lengths in bit times
`define ASIF_IDLE_SHORT 4'hA
`define ASIF_IDLE_LONG 4'hB

// Reset values
`define ASIF_TXE_RST 1'b1
`define ASIF_TXC_RST 1'b1
`define ASIF_IDLE_ARM_RST 1'b1
`define ASIF_DATA_W 8

`endif

//--- common/asif_pkg.sv
// Types shared by the serial interface flag block and its bench.
// Assumes asif_params.svh is on the include path.
`include "asif_params.svh"

package asif_pkg;

  typedef logic [`ASIF_DATA_W-1:0] asif_data_t;

  // Power mode inputs from the system
  typedef struct packed {
    logic cpu_wait;
    logic cpu_stop;
    logic wait_clock_stop;
  } asif_lp_s;

  // Local interrupt enables
  typedef struct packed {
    logic tx_empty_irq_enable;
    logic tx_complete_irq_enable;
    logic rx_full_irq_enable;
    logic idle_irq_enable;
    logic rx_edge_irq_enable;
    logic bit_error_irq_enable;
    logic break_irq_enable;
  } asif_irq_en_s;

  // Software access strobes, one cycle each
  typedef struct packed {
    logic status_one_rd;
    logic data_low_rd;
    logic data_low_wr;
    logic alt_status_wr;
  } asif_sw_s;

  typedef enum logic [1:0] {
    ASIF_RUN = 2'b00,
    ASIF_FROZEN_WAIT = 2'b01,
    ASIF_FROZEN_STOP = 2'b10
  } asif_pmode_e;

endpackage

//--- rtl/asif_buf2.sv
// Two-entry buffer with valid/ready on both sides.
// Same clock and reset on both sides.
`timescale 1ns/1ps
`default_nettype none

module asif_buf2 #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage needs no reset; count guards it
  always_ff @(posedge clk_sys) begin
    if (push) mem_reg[wr_ptr_reg] <= in_data;
  end
endmodule // asif_buf2

`default_nettype wire

//--- rtl/asif_flags.sv
// Flag, interrupt and low-power logic of the async serial interface.
// Assumes the shifter and baud logic run on clk_sys and stop when frame_run is low.
`timescale 1ns/1ps
`default_nettype none
`include "asif_params.svh"

// Summary of operation
// - Wait without clock stop runs normally
// - Clock stop in wait freezes, enables untouched
// - Frozen transfer resumes after wait exit
// - Reset aborts transfers, restores reset state
// - Stop keeps registers, resumes after wake
// - Edge detector works in stop, requests wake
// - Enabled flags and overrun ORed onto one interrupt
// - Empty flag sets on shifter load
// - Complete flag sets when nothing queued
// - Complete clears by sequence or new queue
// - Full flag sets on frame, sequence clears
// - Overrun discards frame, keeps held data
// - Idle after 10 or 11 ones, rearmed
// - Idle clears by status read, data read
// - Edge flag per polarity, write one clears
// - Bit error flag, write one or disable clears
// - Break flag, write one or disable clears
// - Interrupt request stays live during wait
module asif_flags
  import asif_pkg::*;
#(
  parameter int DATA_W = `ASIF_DATA_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Power modes and configuration
  input wire asif_pkg::asif_lp_s lp,
  input wire asif_pkg::asif_irq_en_s irq_en,
  input wire logic rx_polarity,
  input wire logic long_frame,
  input wire logic bit_error_detect_en,
  input wire logic break_detect_en,
  input wire logic receiver_enable_bit,
  input wire logic transmitter_enable_bit,
  // Software access
  input wire asif_pkg::asif_sw_s sw,
  input wire logic [DATA_W-1:0] sw_wdata,
  output logic tx_wr_ready,
  // Transmit shifter side
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [DATA_W-1:0] tx_data,
  input wire logic tx_special_queued,
  input wire logic tx_shift_done,
  // Receive side
  input wire logic rx_pin,
  input wire logic bit_tick,
  input wire logic rx_frame_valid,
  input wire logic [DATA_W-1:0] rx_frame_data,
  input wire logic bit_error_event,
  input wire logic break_event,
  // Status and requests
  output logic [7:0] status_one,
  output logic [7:0] alt_status,
  output logic [DATA_W-1:0] rx_data,
  output logic irq,
  output logic wake_request,
  output logic frame_run,
  output logic rx_enable_out,
  output logic tx_enable_out
);
  import asif_pkg::*;

  logic txe_reg, txc_reg, rxf_reg, idle_reg, or_reg;
  logic edge_reg, berr_reg, brk_reg;
  logic arm_txe_reg, arm_txc_reg, arm_rxf_reg, arm_idle_reg, arm_or_reg;
  logic idle_arm_reg;
  logic [3:0] ones_cnt_reg;
  logic [3:0] ones_cnt_next;
  logic [DATA_W-1:0] rx_data_reg;
  logic rx_meta_reg, rx_sync_reg, rx_prev_reg;
  logic irq_reg, wake_reg, frame_run_reg;
  asif_pmode_e pmode_reg;
  asif_pmode_e pmode_next;
  logic buf_out_valid;
  logic [DATA_W-1:0] buf_out_data;

  // Power mode decode
  wire wait_freeze = lp.cpu_wait && lp.wait_clock_stop;
  wire frozen = (pmode_reg != ASIF_RUN);

  always_comb begin
    case (pmode_reg)
      ASIF_RUN: begin
        if (lp.cpu_stop) pmode_next = ASIF_FROZEN_STOP;
        else if (wait_freeze) pmode_next = ASIF_FROZEN_WAIT;
        else pmode_next = ASIF_RUN;
      end
      ASIF_FROZEN_WAIT: pmode_next = wait_freeze ? ASIF_FROZEN_WAIT : ASIF_RUN;
      ASIF_FROZEN_STOP: pmode_next = lp.cpu_stop ? ASIF_FROZEN_STOP : ASIF_RUN;
      default: pmode_next = ASIF_RUN;
    endcase
  end

  // Transmit data path; frozen shifter takes nothing
  wire tx_pop = buf_out_valid && tx_ready && !frozen;
  asif_buf2 #(.W(DATA_W)) u_txbuf (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(sw.data_low_wr),
    .in_ready(tx_wr_ready),
    .in_data(sw_wdata),
    .out_valid(buf_out_valid),
    .out_ready(tx_ready && !frozen),
    .out_data(buf_out_data)
  );
  assign tx_valid = buf_out_valid && !frozen;
  assign tx_data = buf_out_data;

  // Sequence clears, each needs an armed status read
  wire clr_txe = sw.data_low_wr && arm_txe_reg;
  wire clr_txc = sw.data_low_wr && arm_txc_reg;
  wire clr_rxf = sw.data_low_rd && arm_rxf_reg;
  wire clr_or = sw.data_low_rd && arm_or_reg;
  wire clr_idle = sw.data_low_rd && arm_idle_reg;

  wire txc_set = tx_shift_done && !buf_out_valid && !tx_special_queued;
  wire txc_auto_clr = buf_out_valid || tx_special_queued;
  wire frame_ok = rx_frame_valid && (!rxf_reg || clr_rxf);
  wire frame_lost = rx_frame_valid && rxf_reg && !clr_rxf;

  // Idle run counter on the receive line level
  wire line_high = rx_sync_reg ^ rx_polarity;
  wire [3:0] idle_target = long_frame ? `ASIF_IDLE_LONG : `ASIF_IDLE_SHORT;
  always_comb begin
    ones_cnt_next = ones_cnt_reg;
    if (bit_tick && !frozen) begin
      if (!line_high) ones_cnt_next = 4'h0;
      else if (ones_cnt_reg != idle_target) ones_cnt_next = ones_cnt_reg + 4'h1;
    end
  end
  wire idle_set = idle_arm_reg && (ones_cnt_next == idle_target) && (ones_cnt_reg != idle_target);

  // Active edge; rx_prev_reg follows the second synchroniser stage
  wire active_edge = rx_polarity ? (rx_sync_reg && !rx_prev_reg) : (!rx_sync_reg && rx_prev_reg);

  wire alt_clr_edge = sw.alt_status_wr && sw_wdata[`ASIF_ASR_EDGE_BIT];
  wire alt_clr_berr = sw.alt_status_wr && sw_wdata[`ASIF_ASR_BERR_BIT];
  wire alt_clr_brk = sw.alt_status_wr && sw_wdata[`ASIF_ASR_BRK_BIT];

  wire irq_next = (txe_reg && irq_en.tx_empty_irq_enable) ||
                  (txc_reg && irq_en.tx_complete_irq_enable) ||
                  (rxf_reg && irq_en.rx_full_irq_enable) ||
                  or_reg ||
                  (idle_reg && irq_en.idle_irq_enable) ||
                  (edge_reg && irq_en.rx_edge_irq_enable) ||
                  (berr_reg && irq_en.bit_error_irq_enable) ||
                  (brk_reg && irq_en.break_irq_enable);

  // Everything returns to reset values on nrst
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pmode_reg <= ASIF_RUN;
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      frame_run_reg <= 1'b1;
      ones_cnt_reg <= 4'h0;
      idle_arm_reg <= `ASIF_IDLE_ARM_RST;
    end else begin
      pmode_reg <= pmode_next;
      rx_meta_reg <= rx_pin;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
      irq_reg <= irq_next;
      wake_reg <= lp.cpu_stop && active_edge;
      frame_run_reg <= (pmode_next == ASIF_RUN);
      ones_cnt_reg <= ones_cnt_next;
      if (idle_set) idle_arm_reg <= 1'b0;
      else if (frame_ok) idle_arm_reg <= 1'b1;
    end
  end

  // Status one flags; set wins over clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      txe_reg <= `ASIF_TXE_RST;
      txc_reg <= `ASIF_TXC_RST;
      rxf_reg <= 1'b0;
      or_reg <= 1'b0;
      idle_reg <= 1'b0;
      rx_data_reg <= '0;
    end else begin
      if (tx_pop) txe_reg <= 1'b1;
      else if (clr_txe) txe_reg <= 1'b0;
      if (txc_set) txc_reg <= 1'b1;
      else if (clr_txc || txc_auto_clr) txc_reg <= 1'b0;
      if (frame_ok) rxf_reg <= 1'b1;
      else if (clr_rxf) rxf_reg <= 1'b0;
      if (frame_lost) or_reg <= 1'b1;
      else if (clr_or) or_reg <= 1'b0;
      if (idle_set) idle_reg <= 1'b1;
      else if (clr_idle) idle_reg <= 1'b0;
      if (frame_ok) rx_data_reg <= rx_frame_data;
    end
  end

  // Arming by a status read that saw the flag set
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      arm_txe_reg <= 1'b0;
      arm_txc_reg <= 1'b0;
      arm_rxf_reg <= 1'b0;
      arm_or_reg <= 1'b0;
      arm_idle_reg <= 1'b0;
    end else begin
      if (sw.status_one_rd) begin
        arm_txe_reg <= txe_reg;
        arm_txc_reg <= txc_reg;
        arm_rxf_reg <= rxf_reg;
        arm_or_reg <= or_reg;
        arm_idle_reg <= idle_reg;
      end else begin
        if (sw.data_low_wr) arm_txe_reg <= 1'b0;
        if (sw.data_low_wr) arm_txc_reg <= 1'b0;
        if (sw.data_low_rd) arm_rxf_reg <= 1'b0;
        if (sw.data_low_rd) arm_or_reg <= 1'b0;
        if (sw.data_low_rd) arm_idle_reg <= 1'b0;
      end
    end
  end

  // Alternative status flags
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      edge_reg <= 1'b0;
      berr_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      if (active_edge) edge_reg <= 1'b1;
      else if (alt_clr_edge) edge_reg <= 1'b0;
      if (!bit_error_detect_en) berr_reg <= 1'b0;
      else if (bit_error_event) berr_reg <= 1'b1;
      else if (alt_clr_berr) berr_reg <= 1'b0;
      if (!break_detect_en) brk_reg <= 1'b0;
      else if (break_event) brk_reg <= 1'b1;
      else if (alt_clr_brk) brk_reg <= 1'b0;
    end
  end

  assign status_one = {txe_reg, txc_reg, rxf_reg, idle_reg, or_reg, 3'h0};
  assign alt_status = {edge_reg, 5'h00, berr_reg, brk_reg};
  assign rx_data = rx_data_reg;
  assign irq = irq_reg;
  assign wake_request = wake_reg;
  assign frame_run = frame_run_reg;
  // Enables pass through unchanged in every power mode
  assign rx_enable_out = receiver_enable_bit;
  assign tx_enable_out = transmitter_enable_bit;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_wait_runs_normal: assert property (lp.cpu_wait && !lp.wait_clock_stop && !lp.cpu_stop && !frozen |=> frame_run)
    else $error("frame logic stopped in wait without clock stop");
  a_wait_freezes: assert property (wait_freeze && !lp.cpu_stop ##1 wait_freeze |=> !frame_run && !tx_valid)
    else $error("no freeze in wait with clock stop");
  a_wait_resume: assert property ($fell(wait_freeze) && !lp.cpu_stop |=> ##1 frame_run)
    else $error("no resume after wait exit");
  a_stop_holds: assert property (frozen && !tx_pop && !frame_ok && !sw.data_low_rd |=> $stable(rx_data))
    else $error("data changed while frozen");
  a_edge_wakes: assert property (lp.cpu_stop && active_edge |=> wake_request && edge_reg)
    else $error("edge in stop gave no wake");
  a_irq_or: assert property (or_reg |=> irq)
    else $error("overrun did not raise interrupt");
  a_txe_load: assert property (tx_pop |=> txe_reg)
    else $error("empty flag not set on load");
  a_txc_sets: assert property (txc_set |=> txc_reg)
    else $error("complete flag not set after last bit");
  a_txc_autoclear: assert property (txc_auto_clr && !txc_set |=> !txc_reg)
    else $error("complete flag not cleared by queued data");
  a_full_loads: assert property (frame_ok |=> rxf_reg && (rx_data == $past(rx_frame_data)))
    else $error("frame did not load data and full flag");
  a_overrun_keep: assert property (frame_lost |=> or_reg && rxf_reg && $stable(rx_data))
    else $error("overrun lost held data");
  a_idle_once: assert property (idle_set |=> !idle_arm_reg && idle_reg)
    else $error("idle not disarmed");
  a_edge_sets: assert property (active_edge |=> edge_reg)
    else $error("active edge did not set edge flag");
  a_berr_disable: assert property (!bit_error_detect_en |=> !berr_reg)
    else $error("bit error flag survived disable");
  a_brk_disable: assert property (!break_detect_en |=> !brk_reg)
    else $error("break flag survived disable");
  a_seq_needs_arm: assert property (sw.data_low_rd && !arm_rxf_reg && rxf_reg |=> rxf_reg)
    else $error("full flag cleared without armed read");

  c_wait_freeze: cover property (wait_freeze ##1 frozen ##[1:20] !frozen);
  c_overrun: cover property (frame_ok ##[1:50] frame_lost);
  c_idle: cover property (idle_set);
  c_stop_wake: cover property (lp.cpu_stop && active_edge);
endmodule // asif_flags

`default_nettype wire

//--- sim/asif_far_model.sv
// Behavioural transmit shifter at the far side of the flag block.
// Assumes one clock; it shifts only while frame_run is high.
`timescale 1ns/1ps
`default_nettype none

module asif_far_model #(
  parameter int SHIFT_LEN = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Shifter handshake
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output logic tx_shift_done,
  // Bench control and capture
  input wire logic frame_run,
  input wire logic stall,
  output logic got_stb,
  output logic [7:0] got_word
);
  int cnt;

  // Stall lets the bench play a slow shifter
  assign tx_ready = (cnt == 0) && !stall;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      tx_shift_done <= 1'b0;
      got_stb <= 1'b0;
      got_word <= 8'h00;
    end else begin
      got_stb <= tx_valid && tx_ready;
      tx_shift_done <= frame_run && (cnt == 1);
      if (tx_valid && tx_ready) begin
        cnt <= SHIFT_LEN;
        got_word <= tx_data;
      end else if (frame_run && cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // asif_far_model

`default_nettype wire

//--- sim/asif_flags_tb.sv
// Self-checking bench for asif_flags with a shifter model.
// Assumes the receive framer is replaced by direct pulses.
`timescale 1ns/1ps
`default_nettype none

module asif_flags_tb;
  import asif_pkg::*;
  localparam asif_sw_s SR = 4'h8, DR = 4'h4, DW = 4'h2, AW = 4'h1;
  logic clk_sys = 1'b0, nrst = 1'b0, rx_polarity = 1'b0, long_frame = 1'b0;
  logic bit_error_detect_en = 1'b1, break_detect_en = 1'b1, receiver_enable_bit = 1'b1;
  logic transmitter_enable_bit = 1'b1, tx_special_queued = 1'b0, rx_pin = 1'b1, bit_tick = 1'b0;
  logic rx_frame_valid = 1'b0, bit_error_event = 1'b0, break_event = 1'b0, stall = 1'b0;
  asif_lp_s lp = '0;
  asif_irq_en_s irq_en = '0;
  asif_sw_s sw = '0;
  asif_data_t sw_wdata = '0, rx_frame_data = '0, tx_data, rx_data, got_word, d0, w[3];
  logic [7:0] status_one, alt_status, m;
  logic tx_wr_ready, tx_valid, tx_ready, tx_shift_done, irq, wake_request, frame_run;
  logic rx_enable_out, tx_enable_out, got_stb;
  int n_fail = 0, check_count = 0;
  asif_data_t words[$];

  asif_flags u_asif_flags (.clk_sys, .nrst, .lp, .irq_en, .rx_polarity, .long_frame,
    .bit_error_detect_en, .break_detect_en, .receiver_enable_bit, .transmitter_enable_bit,
    .sw, .sw_wdata, .tx_wr_ready, .tx_valid, .tx_ready, .tx_data, .tx_special_queued,
    .tx_shift_done, .rx_pin, .bit_tick, .rx_frame_valid, .rx_frame_data, .bit_error_event,
    .break_event, .status_one, .alt_status, .rx_data, .irq, .wake_request, .frame_run,
    .rx_enable_out, .tx_enable_out);

  asif_far_model u_asif_far_model (.clk_sys, .nrst, .tx_valid, .tx_ready, .tx_data,
    .tx_shift_done, .frame_run, .stall, .got_stb, .got_word);

  initial forever #10 clk_sys = ~clk_sys;

  always @(posedge clk_sys) if (got_stb) words.push_back(got_word);

  task automatic chk1(string nm, logic e, logic g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic swp(asif_sw_s v, asif_data_t d);
    @(posedge clk_sys) sw <= v;
    sw_wdata <= d;
    @(posedge clk_sys) sw <= '0;
  endtask

  task automatic rx_word(asif_data_t d);
    @(posedge clk_sys) rx_frame_valid <= 1'b1;
    rx_frame_data <= d;
    @(posedge clk_sys) rx_frame_valid <= 1'b0;
  endtask

  task automatic ticks(int n);
    repeat (n) begin
      @(posedge clk_sys) bit_tick <= 1'b1;
      @(posedge clk_sys) bit_tick <= 1'b0;
    end
  endtask

  // Only the two transmit flags stand after reset
  function automatic logic exp_irq(asif_irq_en_s e);
    return e.tx_empty_irq_enable | e.tx_complete_irq_enable;
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  initial begin
    int t;
    void'($urandom(32'h062181D1));
    cyc(3);
    chk8("status_one", 8'hC0, status_one);
    chk8("alt_status", 8'h00, alt_status);
    chk1("irq", 1'b0, irq);
    @(posedge clk_sys) nrst <= 1'b1;
    cyc(4);
    chk1("tx_wr_ready", 1'b1, tx_wr_ready);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys) irq_en <= asif_irq_en_s'(7'($urandom));
      cyc(3);
      chk1("irq", exp_irq(irq_en), irq);
    end
    @(posedge clk_sys) irq_en <= '0;
    d0 = asif_data_t'($urandom);
    rx_word(d0);
    rx_word(~d0);
    cyc(2);
    chk8("rx_data", d0, rx_data);
    chk8("status_one", 8'hE8, status_one);
    chk1("irq", 1'b1, irq);
    swp(DR, 8'h00);
    cyc(2);
    chk8("status_one", 8'hE8, status_one);
    swp(SR, 8'h00);
    swp(DR, 8'h00);
    cyc(2);
    chk8("status_one", 8'hC0, status_one);
    ticks(9);
    cyc(2);
    chk1("idle", 1'b0, status_one[4]);
    ticks(1);
    cyc(2);
    chk1("idle", 1'b1, status_one[4]);
    swp(SR, 8'h00);
    swp(DR, 8'h00);
    cyc(2);
    chk1("idle", 1'b0, status_one[4]);
    // Break the run of ones so the count restarts while disarmed
    @(posedge clk_sys) rx_pin <= 1'b0;
    cyc(3);
    ticks(1);
    @(posedge clk_sys) rx_pin <= 1'b1;
    cyc(3);
    swp(AW, 8'h80);
    ticks(12);
    cyc(2);
    chk1("idle", 1'b0, status_one[4]);
    rx_word(asif_data_t'($urandom));
    swp(SR, 8'h00);
    swp(DR, 8'h00);
    @(posedge clk_sys) long_frame <= 1'b1;
    rx_pin <= 1'b0;
    cyc(4);
    ticks(1);
    @(posedge clk_sys) rx_pin <= 1'b1;
    cyc(4);
    chk8("alt_status", 8'h80, alt_status);
    ticks(10);
    cyc(2);
    chk1("idle", 1'b0, status_one[4]);
    ticks(1);
    cyc(2);
    chk1("idle", 1'b1, status_one[4]);
    @(posedge clk_sys) rx_polarity <= 1'b1;
    cyc(5);
    swp(AW, 8'h80);
    @(posedge clk_sys) rx_pin <= 1'b0;
    cyc(6);
    chk8("alt_status", 8'h00, alt_status);
    @(posedge clk_sys) rx_pin <= 1'b1;
    cyc(6);
    chk8("alt_status", 8'h80, alt_status);
    swp(AW, 8'h80);
    @(posedge clk_sys) rx_polarity <= 1'b0;
    for (int b = 0; b < 4; b++) begin
      m = b[0] ? 8'h02 : 8'h01;
      @(posedge clk_sys) {bit_error_event, break_event} <= m[1:0];
      @(posedge clk_sys) {bit_error_event, break_event} <= 2'h0;
      cyc(2);
      chk8("alt_status", m, alt_status & 8'h03);
      if (b < 2) swp(AW, m);
      else @(posedge clk_sys) {bit_error_detect_en, break_detect_en} <= ~m[1:0];
      cyc(2);
      chk8("alt_status", 8'h00, alt_status & 8'h03);
      @(posedge clk_sys) {bit_error_detect_en, break_detect_en} <= 2'h3;
    end
    // Stalled shifter: two words fill the buffer, the third is refused
    @(posedge clk_sys) stall <= 1'b1;
    swp(SR, 8'h00);
    for (int i = 0; i < 3; i++) begin
      w[i] = asif_data_t'($urandom);
      #1;
      chk1("tx_wr_ready", i < 2, tx_wr_ready);
      swp(DW, w[i]);
    end
    cyc(2);
    chk8("status_one", 8'h00, status_one & 8'hC0);
    // Shifter stays stalled until the freeze has landed
    @(posedge clk_sys) lp <= 3'h5;
    transmitter_enable_bit <= 1'b0;
    irq_en <= 7'h08;
    cyc(3);
    chk1("frame_run", 1'b0, frame_run);
    chk1("tx_valid", 1'b0, tx_valid);
    chk1("rx_enable_out", 1'b1, rx_enable_out);
    chk1("tx_enable_out", 1'b0, tx_enable_out);
    chk1("irq", 1'b1, irq);
    @(posedge clk_sys) stall <= 1'b0;
    cyc(10);
    chk8("count", 8'h00, 8'(words.size()));
    @(posedge clk_sys) lp <= 3'h4;
    transmitter_enable_bit <= 1'b1;
    cyc(3);
    chk1("frame_run", 1'b1, frame_run);
    for (t = 0; t < 300 && status_one[6] !== 1'b1; t++) cyc(1);
    chk8("count", 8'h02, 8'(words.size()));
    chk8("word0", w[0], words[0]);
    chk8("word1", w[1], words[1]);
    chk8("status_one", 8'hC0, status_one & 8'hC0);
    @(posedge clk_sys) lp <= 3'h2;
    cyc(3);
    chk1("frame_run", 1'b0, frame_run);
    @(posedge clk_sys) rx_pin <= 1'b0;
    for (t = 0; t < 10 && wake_request !== 1'b1; t++) cyc(1);
    chk1("wake_request", 1'b1, wake_request);
    chk8("status_one", 8'hC0, status_one & 8'hC0);
    @(posedge clk_sys) lp <= 3'h0;
    rx_pin <= 1'b1;
    tx_special_queued <= 1'b1;
    cyc(3);
    chk1("complete", 1'b0, status_one[6]);
    rx_word(8'hA5);
    @(posedge clk_sys) nrst <= 1'b0;
    cyc(1);
    chk8("status_one", 8'hC0, status_one);
    chk8("rx_data", 8'h00, rx_data);
    end_of_test();
  end
endmodule // asif_flags_tb

`default_nettype wire
